//--- design/fpx_pkg.sv
package fpx_pkg;

    // host i/o ports of the extension bank
    localparam logic [15:0] FPX_INDEX_PORT = 16'h03D0;
    localparam logic [15:0] FPX_DATA_PORT = 16'h03D1;

    // register indexes, as written to the index port
    localparam logic [7:0] FPX_IDX_HCOMP = 8'h40;
    localparam logic [7:0] FPX_IDX_VCOMP = 8'h48;
    localparam logic [7:0] FPX_IDX_VSTRETCH = 8'h4E;
    localparam logic [7:0] FPX_IDX_LINK = 8'h60;
    localparam logic [7:0] FPX_IDX_SEED_R = 8'h70;
    localparam logic [7:0] FPX_IDX_SEED_G = 8'h71;
    localparam logic [7:0] FPX_IDX_SEED_B = 8'h72;
    localparam logic [7:0] FPX_IDX_DCTRL = 8'h73;

    // storage slots inside the bank
    localparam int FPX_NUM_REGS = 8;
    localparam logic [2:0] FPX_SLOT_HCOMP = 3'h0;
    localparam logic [2:0] FPX_SLOT_VCOMP = 3'h1;
    localparam logic [2:0] FPX_SLOT_VSTRETCH = 3'h2;
    localparam logic [2:0] FPX_SLOT_LINK = 3'h3;
    localparam logic [2:0] FPX_SLOT_SEED_R = 3'h4;
    localparam logic [2:0] FPX_SLOT_SEED_G = 3'h5;
    localparam logic [2:0] FPX_SLOT_SEED_B = 3'h6;
    localparam logic [2:0] FPX_SLOT_DCTRL = 3'h7;

    // reset value of every register and of the index latch
    localparam logic [7:0] FPX_RST_REG = 8'h00;
    // read value for an index that selects nothing
    localparam logic [7:0] FPX_UNMAPPED = 8'h00;

    // field positions
    localparam int FPX_VCOMP_EN_BIT = 0;
    localparam int FPX_VS_G600_BIT = 5;
    localparam int FPX_VS_G480_BIT = 4;
    localparam int FPX_VS_G400_BIT = 3;
    localparam int FPX_VS_G350_BIT = 2;
    localparam int FPX_VS_T400_BIT = 1;
    localparam int FPX_VS_T350_BIT = 0;
    localparam int FPX_VS_WIDTH = 6;

    // display heights as line counts (600, 480, 400, 350)
    localparam logic [10:0] FPX_LINES_600 = 11'h258;
    localparam logic [10:0] FPX_LINES_480 = 11'h1E0;
    localparam logic [10:0] FPX_LINES_400 = 11'h190;
    localparam logic [10:0] FPX_LINES_350 = 11'h15E;

    // host i/o request, all fields valid in one clock
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } fpx_io_req_t;

    // link control register layout, msb first
    typedef struct packed {
        logic tristate;
        logic side3;
        logic side2;
        logic rsvd;
        logic data_fall;
        logic ctrl_fall;
        logic dot_src;
        logic disable_link;
    } fpx_link_ctrl_t;

    // dither control register layout, msb first
    typedef struct packed {
        logic enable;
        logic scheme_one;
        logic [1:0] shades;
        logic [3:0] beat;
    } fpx_dctrl_t;

    // settings handed to the dithering engine
    typedef struct packed {
        fpx_dctrl_t ctrl;
        logic [7:0] seed_r;
        logic [7:0] seed_g;
        logic [7:0] seed_b;
    } fpx_dither_t;

    // index to {hit, slot}; used by write and read decode
    function automatic logic [3:0] fpx_slot(input logic [7:0] idx);
        case (idx)
            FPX_IDX_HCOMP: fpx_slot = {1'b1, FPX_SLOT_HCOMP};
            FPX_IDX_VCOMP: fpx_slot = {1'b1, FPX_SLOT_VCOMP};
            FPX_IDX_VSTRETCH: fpx_slot = {1'b1, FPX_SLOT_VSTRETCH};
            FPX_IDX_LINK: fpx_slot = {1'b1, FPX_SLOT_LINK};
            FPX_IDX_SEED_R: fpx_slot = {1'b1, FPX_SLOT_SEED_R};
            FPX_IDX_SEED_G: fpx_slot = {1'b1, FPX_SLOT_SEED_G};
            FPX_IDX_SEED_B: fpx_slot = {1'b1, FPX_SLOT_SEED_B};
            FPX_IDX_DCTRL: fpx_slot = {1'b1, FPX_SLOT_DCTRL};
            default: fpx_slot = 4'h0;
        endcase
    endfunction : fpx_slot

endpackage : fpx_pkg

//--- design/fpx_height_sel.sv
`timescale 1ns/1ns
// picks the qualifier bit for the current display height
module fpx_height_sel
    import fpx_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [10:0] i_lines,
    input wire logic i_text_mode,
    input wire logic i_master_en,
    input wire logic [5:0] i_qual,
    output logic o_allow
);
    // whole state of this module
    typedef struct packed {
        logic allow;
    } fpx_hsel_t;

    fpx_hsel_t st_q;
    fpx_hsel_t st_d;

    // heights with no qualifier bit are never stretched here
    always_comb
    begin
        st_d = st_q;
        st_d.allow = 1'b0;
        if (i_master_en)
        begin
            if (i_text_mode)
            begin
                case (i_lines)
                    FPX_LINES_400: st_d.allow = i_qual[FPX_VS_T400_BIT];
                    FPX_LINES_350: st_d.allow = i_qual[FPX_VS_T350_BIT];
                    default: st_d.allow = 1'b0;
                endcase
            end
            else
            begin
                case (i_lines)
                    FPX_LINES_600: st_d.allow = i_qual[FPX_VS_G600_BIT];
                    FPX_LINES_480: st_d.allow = i_qual[FPX_VS_G480_BIT];
                    FPX_LINES_400: st_d.allow = i_qual[FPX_VS_G400_BIT];
                    FPX_LINES_350: st_d.allow = i_qual[FPX_VS_G350_BIT];
                    default: st_d.allow = 1'b0;
                endcase
            end
        end
    end

    // state register
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign o_allow = st_q.allow;

endmodule : fpx_height_sel

//--- design/fpx_edge_cap.sv
`timescale 1ns/1ns
// captures data on a chosen edge of a sampled link clock
module fpx_edge_cap #(
    parameter int WIDTH = 8
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_link_clk,
    input wire logic i_fall_sel,
    input wire logic i_enable,
    input wire logic [WIDTH-1:0] i_data,
    output logic [WIDTH-1:0] o_data
);
    // whole state of this module
    typedef struct packed {
        logic prev;
        logic [WIDTH-1:0] data;
    } fpx_ecap_t;

    fpx_ecap_t st_q;
    fpx_ecap_t st_d;
    logic edge_hit;

    // edge picked by the select bit; holds while disabled
    always_comb
    begin
        st_d = st_q;
        st_d.prev = i_link_clk;
        if (i_fall_sel)
            edge_hit = st_q.prev && !i_link_clk;
        else
            edge_hit = !st_q.prev && i_link_clk;
        if (i_enable && edge_hit)
            st_d.data = i_data;
    end

    // state register
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign o_data = st_q.data;

endmodule : fpx_edge_cap

//--- design/fpx_regs.sv
`timescale 1ns/1ns
// Functional notes
// (R1) six per-height stretch permit bits
// (R2) height bit gated by master enables; code gates it by vertical compensation bit 0 only
// (R3) software writes stretch bits before compensation
// (R4) link bit 7 floats all panel outputs
// (R5) bits 6 and 5 drive side channels
// (R6) software writes zero to bit 4
// (R7) bit 3 picks data capture edge
// (R8) bit 2 picks control capture edge
// (R9) bit 1 picks shift or dot clock
// (R10) bit 0 set disables the link
// (R11) enabled link copies general pin one
// (R12) three 8-bit dither seeds per color
// (R13) dither enable and scheme select bits
// (R14) two bits select shades per color
// (R15) four-bit horizontal beat suppression factor
// (R16) index port then data port access
// (R17) vertical compensation needs master enable bit
// (R18) every register reads back last write
module fpx_regs
    import fpx_pkg::*;
#(
    parameter int PIX_W = 24,
    parameter int CTRL_W = 4
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input fpx_pkg::fpx_io_req_t i_io,
    output logic [7:0] o_io_rdata,
    output logic o_io_rd_valid,
    input wire logic [10:0] i_vde_lines,
    input wire logic i_text_mode,
    output logic o_vstretch_allow,
    output logic [7:0] o_hcomp,
    output logic [7:0] o_vcomp,
    input wire logic i_panel_shift_clock,
    input wire logic i_dot_clock,
    input wire logic i_general_pin_one,
    input wire logic [PIX_W-1:0] i_pix_data,
    input wire logic [CTRL_W-1:0] i_pix_ctrl,
    output logic o_link_enable,
    output logic [PIX_W-1:0] o_link_pix_data,
    output logic [CTRL_W-1:0] o_link_pix_ctrl,
    output logic o_side_channel_out_1,
    output logic o_side_channel_out_2,
    output logic o_side_channel_out_3,
    output logic o_panel_oe,
    output fpx_pkg::fpx_dither_t o_dither
);
    import fpx_pkg::*;

    // whole state of the bank
    typedef struct packed {
        logic [7:0] index;
        logic [FPX_NUM_REGS-1:0][7:0] bank;
        logic [7:0] rdata;
        logic rd_valid;
        logic side1;
        logic gpio_s1;
        logic gpio_s2;
        logic shf_s1;
        logic shf_s2;
        logic dck_s1;
        logic dck_s2;
        logic [PIX_W-1:0] pix_s1;
        logic [PIX_W-1:0] pix_s2;
        logic [CTRL_W-1:0] ctl_s1;
        logic [CTRL_W-1:0] ctl_s2;
    } fpx_state_t;

    fpx_state_t st_q;
    fpx_state_t st_d;
    logic [1:0] rst_pipe_q; // reset release pipeline
    logic rst_n; // synchronised reset, active low
    fpx_link_ctrl_t lnk; // link control view of the bank
    logic [3:0] wr_slot; // decode of the held index
    logic link_input_clock; // selected link input clock level
    logic link_on; // link running

    // reset asserts at once, releases after two edges
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            rst_pipe_q <= 2'h0;
        else
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end

    assign rst_n = rst_pipe_q[1];

    // register views used by the datapath
    assign lnk = fpx_link_ctrl_t'(st_q.bank[FPX_SLOT_LINK]);
    assign wr_slot = fpx_slot(st_q.index);
    assign link_on = !lnk.disable_link; // [R10]

    // a clock swap mid-line can show one false edge; only
    // change the source while the panel is idle
    assign link_input_clock = lnk.dot_src ? st_q.dck_s2 : st_q.shf_s2; // [R9]

    // next state: host port decode, read data, pin sync
    always_comb
    begin
        st_d = st_q;
        st_d.rd_valid = 1'b0;
        // index port write selects the register
        if (i_io.wr && i_io.addr == FPX_INDEX_PORT) // [R16]
            st_d.index = i_io.wdata;
        // data port write lands in the selected slot;
        // reserved bits are stored as written
        if (i_io.wr && i_io.addr == FPX_DATA_PORT && wr_slot[3]) // [R16]
            st_d.bank[wr_slot[2:0]] = i_io.wdata; // [R18]
        // reads answer one cycle later
        if (i_io.rd)
        begin
            st_d.rd_valid = 1'b1;
            if (i_io.addr == FPX_INDEX_PORT)
                st_d.rdata = st_q.index;
            else if (i_io.addr == FPX_DATA_PORT && wr_slot[3])
                st_d.rdata = st_q.bank[wr_slot[2:0]]; // [R18]
            else
                st_d.rdata = FPX_UNMAPPED;
        end
        // pins from other domains pass two flops
        st_d.gpio_s1 = i_general_pin_one;
        st_d.gpio_s2 = st_q.gpio_s1;
        st_d.shf_s1 = i_panel_shift_clock;
        st_d.shf_s2 = st_q.shf_s1;
        st_d.dck_s1 = i_dot_clock;
        st_d.dck_s2 = st_q.dck_s1;
        st_d.pix_s1 = i_pix_data;
        st_d.pix_s2 = st_q.pix_s1;
        st_d.ctl_s1 = i_pix_ctrl;
        st_d.ctl_s2 = st_q.ctl_s1;
        // side channel one follows the pin while enabled
        st_d.side1 = link_on && st_q.gpio_s2; // [R11]
    end

    // state register; every documented reset value is zero
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // per-height qualifier under the master enable
    fpx_height_sel u_height (
        .i_clock(i_clock),
        .i_rst_n(rst_n),
        .i_lines(i_vde_lines),
        .i_text_mode(i_text_mode),
        .i_master_en(st_q.bank[FPX_SLOT_VCOMP][FPX_VCOMP_EN_BIT]), // [R17]
        .i_qual(st_q.bank[FPX_SLOT_VSTRETCH][FPX_VS_WIDTH-1:0]), // [R1] [R2]
        .o_allow(o_vstretch_allow)
    );

    // pixel data capture on the selected edge
    fpx_edge_cap #(
        .WIDTH(PIX_W)
    ) u_data_cap (
        .i_clock(i_clock),
        .i_rst_n(rst_n),
        .i_link_clk(link_input_clock),
        .i_fall_sel(lnk.data_fall), // [R7]
        .i_enable(link_on),
        .i_data(st_q.pix_s2),
        .o_data(o_link_pix_data)
    );

    // control signal capture on its own edge
    fpx_edge_cap #(
        .WIDTH(CTRL_W)
    ) u_ctrl_cap (
        .i_clock(i_clock),
        .i_rst_n(rst_n),
        .i_link_clk(link_input_clock),
        .i_fall_sel(lnk.ctrl_fall), // [R8]
        .i_enable(link_on),
        .i_data(st_q.ctl_s2),
        .o_data(o_link_pix_ctrl)
    );

    // outputs come straight from the bank flops
    assign o_io_rdata = st_q.rdata;
    assign o_io_rd_valid = st_q.rd_valid;
    assign o_hcomp = st_q.bank[FPX_SLOT_HCOMP];
    assign o_vcomp = st_q.bank[FPX_SLOT_VCOMP];
    assign o_link_enable = link_on; // [R10]
    assign o_panel_oe = !lnk.tristate; // [R4]
    assign o_side_channel_out_3 = lnk.side3; // [R5]
    assign o_side_channel_out_2 = lnk.side2; // [R5]
    assign o_side_channel_out_1 = st_q.side1;
    // bit 4 is only stored; hardware gives it no meaning
    assign o_dither.ctrl = fpx_dctrl_t'(st_q.bank[FPX_SLOT_DCTRL]); // [R13]
    assign o_dither.seed_r = st_q.bank[FPX_SLOT_SEED_R]; // [R12]
    assign o_dither.seed_g = st_q.bank[FPX_SLOT_SEED_G]; // [R12]
    assign o_dither.seed_b = st_q.bank[FPX_SLOT_SEED_B]; // [R12]

    // checks on the bank, all in the synchronised reset
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!rst_n);

    // index port write followed by data port write
    sequence s_sel(logic [7:0] idx);
        i_io.wr && i_io.addr == FPX_INDEX_PORT && i_io.wdata == idx;
    endsequence

    sequence s_data_wr;
        i_io.wr && i_io.addr == FPX_DATA_PORT;
    endsequence

    sequence s_data_rd;
        i_io.rd && !i_io.wr && i_io.addr == FPX_DATA_PORT;
    endsequence

    sequence s_link_wr;
        s_sel(FPX_IDX_LINK) ##1 s_data_wr;
    endsequence

    sequence s_dctrl_wr;
        s_sel(FPX_IDX_DCTRL) ##1 s_data_wr;
    endsequence

    read_back_a: assert property ( // [R18] [R16]
        (s_data_wr and wr_slot[3]) ##1 s_data_rd
        |=> o_io_rd_valid && o_io_rdata == $past(i_io.wdata, 2))
        else $error("bank read does not return last write");

    rd_answer_a: assert property ( // [R16]
        o_io_rd_valid == $past(i_io.rd))
        else $error("read not answered in next cycle");

    tristate_oe_a: assert property ( // [R4]
        s_link_wr |=> o_panel_oe == !$past(i_io.wdata[7]))
        else $error("panel enable does not follow bit 7");

    side_chan_a: assert property ( // [R5]
        s_link_wr |=> o_side_channel_out_3 == $past(i_io.wdata[6])
            && o_side_channel_out_2 == $past(i_io.wdata[5]))
        else $error("side channels do not follow bits 6 and 5");

    side_one_a: assert property ( // [R11]
        link_on ##1 link_on
        |-> o_side_channel_out_1 == $past(st_q.gpio_s2))
        else $error("side channel one does not follow pin one");

    side_off_a: assert property ( // [R11]
        !link_on |=> !o_side_channel_out_1)
        else $error("side channel one high with link off");

    data_rise_a: assert property ( // [R7] [R9]
        link_on && !lnk.data_fall && link_input_clock && !$past(link_input_clock)
        |=> o_link_pix_data == $past(st_q.pix_s2))
        else $error("pixel data not taken on rising edge");

    ctrl_fall_a: assert property ( // [R8] [R9]
        link_on && lnk.ctrl_fall && !link_input_clock && $past(link_input_clock)
        |=> o_link_pix_ctrl == $past(st_q.ctl_s2))
        else $error("control not taken on falling edge");

    data_fall_a: assert property ( // [R7] [R9]
        link_on && lnk.data_fall && !link_input_clock && $past(link_input_clock)
        |=> o_link_pix_data == $past(st_q.pix_s2))
        else $error("pixel data not taken on falling edge");

    ctrl_rise_a: assert property ( // [R8] [R9]
        link_on && !lnk.ctrl_fall && link_input_clock && !$past(link_input_clock)
        |=> o_link_pix_ctrl == $past(st_q.ctl_s2))
        else $error("control not taken on rising edge");

    link_off_a: assert property ( // [R10]
        !link_on |=> $stable(o_link_pix_data) && $stable(o_link_pix_ctrl))
        else $error("capture moved while link disabled");

    dither_ctl_a: assert property ( // [R13] [R14] [R15]
        s_dctrl_wr |=> o_dither.ctrl.enable == $past(i_io.wdata[7])
            && o_dither.ctrl.scheme_one == $past(i_io.wdata[6])
            && o_dither.ctrl.shades == $past(i_io.wdata[5:4])
            && o_dither.ctrl.beat == $past(i_io.wdata[3:0]))
        else $error("dither control fields mismatch");

    seed_red_a: assert property ( // [R12]
        s_sel(FPX_IDX_SEED_R) ##1 s_data_wr
        |=> o_dither.seed_r == $past(i_io.wdata))
        else $error("red seed not stored");

    stretch_600_a: assert property ( // [R1] [R2]
        i_vde_lines == FPX_LINES_600 && !i_text_mode
        |=> o_vstretch_allow == ($past(o_vcomp[FPX_VCOMP_EN_BIT])
            && $past(st_q.bank[FPX_SLOT_VSTRETCH][FPX_VS_G600_BIT])))
        else $error("600-line stretch permit wrong");

    stretch_master_a: assert property ( // [R17]
        !o_vcomp[FPX_VCOMP_EN_BIT] |=> !o_vstretch_allow)
        else $error("stretch allowed without master enable");

endmodule : fpx_regs

//--- tb/tb.sv
`timescale 1ns/1ns
// self-checking bench for the flat panel extension register bank
module tb;
    import fpx_pkg::*;

    localparam int PIX_W = 24;
    localparam int CTRL_W = 4;
    // whole run needs about a thousand cycles; ceiling leaves wide margin
    localparam int MAX_CYCLES = 20000;
    // index of each storage slot, in slot order
    localparam logic [7:0] IDX_TAB [8] = '{FPX_IDX_HCOMP, FPX_IDX_VCOMP,
        FPX_IDX_VSTRETCH, FPX_IDX_LINK, FPX_IDX_SEED_R, FPX_IDX_SEED_G,
        FPX_IDX_SEED_B, FPX_IDX_DCTRL};
    // graphics heights in qualifier bit order 5..2
    localparam logic [10:0] HTAB [4] = '{FPX_LINES_600, FPX_LINES_480,
        FPX_LINES_400, FPX_LINES_350};

    logic i_clock = 1'b0;
    logic i_rst_b;
    fpx_io_req_t i_io = '0;
    logic [10:0] i_vde_lines = '0;
    logic i_text_mode = 1'b0;
    logic i_panel_shift_clock = 1'b0; // idle low between pulses
    logic i_dot_clock = 1'b0;
    logic i_general_pin_one = 1'b0;
    logic [PIX_W-1:0] i_pix_data = '0;
    logic [CTRL_W-1:0] i_pix_ctrl = '0;
    logic [7:0] o_io_rdata;
    logic o_io_rd_valid;
    logic o_vstretch_allow;
    logic [7:0] o_hcomp;
    logic [7:0] o_vcomp;
    logic o_link_enable;
    logic [PIX_W-1:0] o_link_pix_data;
    logic [CTRL_W-1:0] o_link_pix_ctrl;
    logic o_side_channel_out_1;
    logic o_side_channel_out_2;
    logic o_side_channel_out_3;
    logic o_panel_oe;
    fpx_dither_t o_dither;

    int seed = 33846; // fixed so every run repeats
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [7:0] shadow [8]; // expected contents of each slot
    logic [7:0] rd_val;
    logic [31:0] r;
    logic [PIX_W-1:0] exp_d = '0; // last value the link should hold
    logic [CTRL_W-1:0] exp_c = '0;

    fpx_regs #(
        .PIX_W(PIX_W),
        .CTRL_W(CTRL_W)
    ) dut_u (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_io(i_io),
        .o_io_rdata(o_io_rdata),
        .o_io_rd_valid(o_io_rd_valid),
        .i_vde_lines(i_vde_lines),
        .i_text_mode(i_text_mode),
        .o_vstretch_allow(o_vstretch_allow),
        .o_hcomp(o_hcomp),
        .o_vcomp(o_vcomp),
        .i_panel_shift_clock(i_panel_shift_clock),
        .i_dot_clock(i_dot_clock),
        .i_general_pin_one(i_general_pin_one),
        .i_pix_data(i_pix_data),
        .i_pix_ctrl(i_pix_ctrl),
        .o_link_enable(o_link_enable),
        .o_link_pix_data(o_link_pix_data),
        .o_link_pix_ctrl(o_link_pix_ctrl),
        .o_side_channel_out_1(o_side_channel_out_1),
        .o_side_channel_out_2(o_side_channel_out_2),
        .o_side_channel_out_3(o_side_channel_out_3),
        .o_panel_oe(o_panel_oe),
        .o_dither(o_dither)
    );

    // free-running 100 mhz clock
    always #5 i_clock = ~i_clock;

    // hang guard: a stuck sequence ends the run as a failure
    always @(posedge i_clock)
    begin
        cycles <= cycles + 1;
        if (cycles == MAX_CYCLES)
        begin
            fails++;
            test_done();
        end
    end

    // counts line, verdict, end of run
    task automatic test_done();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    // four-state compare; an unknown matches only the same unknown
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        n_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH at %0t: %s got %0h exp %0h", $time, what,
                     got, exp);
            fails++;
        end
    endtask : check

    // let n edges pass, then step just past the last one
    task automatic step(input int n);
        repeat (n)
        begin
            @(posedge i_clock);
            #1;
        end
    endtask : step

    // reset held 16 cycles; requests wait for the internal release
    task automatic do_reset();
        i_rst_b = 1'b0;
        step(16);
        i_rst_b = 1'b1;
        step(4);
    endtask : do_reset

    // bus tasks leave the strobe up so back-to-back cycles stay clean
    task automatic io_wr(input logic [15:0] addr, input logic [7:0] data);
        i_io.wr = 1'b1;
        i_io.rd = 1'b0;
        i_io.addr = addr;
        i_io.wdata = data;
        step(1);
    endtask : io_wr

    task automatic io_rd(input logic [15:0] addr, output logic [7:0] data);
        i_io.wr = 1'b0;
        i_io.rd = 1'b1;
        i_io.addr = addr;
        step(1);
        check(o_io_rd_valid, 1'b1, "read valid");
        data = o_io_rdata;
    endtask : io_rd

    task automatic io_idle();
        i_io.wr = 1'b0;
        i_io.rd = 1'b0;
        step(1);
    endtask : io_idle

    // index write, then data access in the very next cycle
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] data);
        io_wr(FPX_INDEX_PORT, idx);
        io_wr(FPX_DATA_PORT, data);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] idx, output logic [7:0] data);
        io_wr(FPX_INDEX_PORT, idx);
        io_rd(FPX_DATA_PORT, data);
    endtask : reg_rd

    // every slot reads back zero after reset
    task automatic check_reset_vals();
        for (int i = 0; i < 8; i++)
        begin
            reg_rd(IDX_TAB[i], rd_val);
            check(rd_val, FPX_RST_REG, "reset value");
        end
        io_idle();
    endtask : check_reset_vals

    // stretch permit from height, mode, qualifier and master enable
    function automatic logic exp_allow(input logic [10:0] lines,
        input logic txt, input logic [7:0] q, input logic [7:0] vc);
        logic b;
        b = 1'b0;
        if (!txt)
        begin
            for (int k = 0; k < 4; k++)
                if (lines == HTAB[k])
                    b = q[5-k];
        end
        else if (lines == FPX_LINES_400)
            b = q[1];
        else if (lines == FPX_LINES_350)
            b = q[0];
        return b & vc[FPX_VCOMP_EN_BIT];
    endfunction : exp_allow

    // one capture trial: pulse the chosen link clock once
    task automatic cap_case(input logic [7:0] cfg, input logic use_dot);
        logic live;
        logic [PIX_W-1:0] nd;
        logic [CTRL_W-1:0] nc;
        live = !cfg[0] && (cfg[1] == use_dot);
        reg_wr(FPX_IDX_LINK, cfg);
        io_idle();
        // let a false edge from the source switch pass first
        step(6);
        r = $random(seed);
        nd = r[PIX_W-1:0];
        nc = r[31:32-CTRL_W];
        i_pix_data = nd;
        i_pix_ctrl = nc;
        step(6);
        if (use_dot)
            i_dot_clock = 1'b1;
        else
            i_panel_shift_clock = 1'b1;
        step(6);
        if (live && !cfg[3])
            exp_d = nd;
        if (live && !cfg[2])
            exp_c = nc;
        check(o_link_pix_data, exp_d, "data after rise");
        check(o_link_pix_ctrl, exp_c, "ctrl after rise");
        i_dot_clock = 1'b0;
        i_panel_shift_clock = 1'b0;
        step(6);
        if (live && cfg[3])
            exp_d = nd;
        if (live && cfg[2])
            exp_c = nc;
        check(o_link_pix_data, exp_d, "data after fall");
        check(o_link_pix_ctrl, exp_c, "ctrl after fall");
        // restore inputs so a later false edge changes nothing
        i_pix_data = exp_d;
        i_pix_ctrl = exp_c;
        step(4);
    endtask : cap_case

    // main sequence
    initial
    begin
        do_reset();
        check(o_panel_oe, 1'b1, "oe after reset");
        check(o_link_enable, 1'b1, "link after reset");
        check({o_side_channel_out_3, o_side_channel_out_2}, 2'b00, "side");
        check_reset_vals();
        // random contents in every slot, then read all back
        for (int i = 0; i < 8; i++)
        begin
            r = $random(seed);
            shadow[i] = r[7:0];
            if (i == FPX_SLOT_LINK)
                shadow[i][4] = 1'b0;
            reg_wr(IDX_TAB[i], shadow[i]);
            io_rd(FPX_DATA_PORT, rd_val);
            check(rd_val, shadow[i], "write then read");
        end
        io_idle();
        for (int i = 0; i < 8; i++)
        begin
            reg_rd(IDX_TAB[i], rd_val);
            check(rd_val, shadow[i], "readback");
        end
        io_idle();
        check(o_hcomp, shadow[FPX_SLOT_HCOMP], "hcomp");
        check(o_vcomp, shadow[FPX_SLOT_VCOMP], "vcomp");
        check(o_dither, {shadow[7], shadow[4], shadow[5], shadow[6]}, "dith");
        // every shade code, with enable and scheme flipping
        for (int k = 0; k < 4; k++)
        begin
            rd_val = {k[0], ~k[0], k[1:0], 4'hF - k[3:0]};
            reg_wr(FPX_IDX_DCTRL, rd_val);
            check(o_dither.ctrl.enable, rd_val[7], "enable");
            check(o_dither.ctrl.scheme_one, rd_val[6], "scheme");
            check(o_dither.ctrl.shades, rd_val[5:4], "shades");
            check(o_dither.ctrl.beat, rd_val[3:0], "beat");
        end
        // unmapped index: write ignored, index reads back, other reads give zero
        reg_wr(8'h55, 8'hA5);
        io_rd(FPX_INDEX_PORT, rd_val);
        check(rd_val, 8'h55, "index readback");
        io_rd(FPX_DATA_PORT, rd_val);
        check(rd_val, FPX_UNMAPPED, "unmapped data");
        io_rd(16'h03D2, rd_val);
        check(rd_val, FPX_UNMAPPED, "other port");
        reg_rd(FPX_IDX_HCOMP, rd_val);
        check(rd_val, shadow[FPX_SLOT_HCOMP], "untouched");
        io_idle();
        // link control bits against pins, with random pin one
        for (int n = 0; n < 24; n++)
        begin
            r = $random(seed);
            r[4] = 1'b0;
            reg_wr(FPX_IDX_LINK, r[7:0]);
            io_idle();
            i_general_pin_one = r[12];
            step(5);
            check(o_panel_oe, !r[7], "panel oe");
            check(o_side_channel_out_3, r[6], "side 3");
            check(o_side_channel_out_2, r[5], "side 2");
            check(o_link_enable, !r[0], "link enable");
            check(o_side_channel_out_1, ~r[0] & r[12], "side 1");
            reg_rd(FPX_IDX_LINK, rd_val);
            check(rd_val, r[7:0], "link readback");
        end
        io_idle();
        // stretch permit over heights, modes and master enable
        for (int n = 0; n < 40; n++)
        begin
            r = $random(seed);
            reg_wr(FPX_IDX_VSTRETCH, {2'b00, r[13:8]});
            reg_wr(FPX_IDX_VCOMP, r[4] ? 8'h11 : 8'h10);
            reg_wr(FPX_IDX_HCOMP, 8'h01);
            io_idle();
            i_text_mode = r[0];
            if (r[0])
                i_vde_lines = r[2] ? FPX_LINES_400 : FPX_LINES_350;
            else
                i_vde_lines = HTAB[r[3:2]];
            step(4);
            check(o_vstretch_allow, exp_allow(i_vde_lines, r[0],
                {2'b00, r[13:8]}, r[4] ? 8'h11 : 8'h10), "allow");
        end
        // capture edges and clock sources, then a disabled link
        cap_case(8'h00, 1'b0);
        cap_case(8'h0C, 1'b0);
        cap_case(8'h08, 1'b0);
        cap_case(8'h04, 1'b0);
        cap_case(8'h02, 1'b1);
        cap_case(8'h0E, 1'b0);
        cap_case(8'h01, 1'b0);
        // second reset in mid-run clears what was written
        do_reset();
        check(o_panel_oe, 1'b1, "oe after reset");
        check_reset_vals();
        test_done();
    end

endmodule : tb
